// *** tc8_pkg.sv ***
// Purpose: constants and types for the 8-bit timer/counter with two compare units
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
// Notes:   register offsets and bit layouts are house choices
package tc8_pkg;
   localparam logic [7:0] TC8_CTRL_A_OFS  = 8'h00;
   localparam logic [7:0] TC8_CTRL_B_OFS  = 8'h04;
   localparam logic [7:0] TC8_COUNT_OFS   = 8'h08;
   localparam logic [7:0] TC8_CMPA_OFS    = 8'h0C;
   localparam logic [7:0] TC8_CMPB_OFS    = 8'h10;
   localparam logic [7:0] TC8_MASK_OFS    = 8'h14;
   localparam logic [7:0] TC8_FLAG_OFS    = 8'h18;
   localparam logic [7:0] TC8_POWER_OFS   = 8'h1C;
   localparam logic [7:0] TC8_ACK_OFS     = 8'h20;
   // control a: [7:6] mode a, [5:4] mode b, [1:0] waveform bits 1:0
   localparam int TC8_COMA_POS = 6;
   localparam int TC8_COMB_POS = 4;
   // control b: [7] force a, [6] force b, [3] waveform bit 2, [2:0] clock select
   localparam int TC8_FOCA_POS = 7;
   localparam int TC8_FOCB_POS = 6;
   localparam int TC8_WGM2_POS = 3;
   // flags and masks: [2] compare b, [1] compare a, [0] overflow
   localparam int TC8_OVF_POS  = 0;
   localparam int TC8_OCFA_POS = 1;
   localparam int TC8_OCFB_POS = 2;
   localparam logic [7:0] TC8_BOTTOM = 8'h00;
   localparam logic [7:0] TC8_MAX    = 8'hFF;
   localparam logic [7:0] TC8_RESET8 = 8'h00;
   localparam logic [1:0] TC8_RESP_OKAY   = 2'h0;
   localparam logic [1:0] TC8_RESP_SLVERR = 2'h2;
   // prescaler taps, counted in i/o clock cycles
   localparam int TC8_DIV8    = 8;
   localparam int TC8_DIV64   = 64;
   localparam int TC8_DIV256  = 256;
   localparam int TC8_DIV1024 = 1024;
   typedef enum logic [2:0] {
      TC8_CS_STOP = 3'h0, TC8_CS_DIV1 = 3'h1, TC8_CS_DIV8 = 3'h2, TC8_CS_DIV64 = 3'h3,
      TC8_CS_DIV256 = 3'h4, TC8_CS_DIV1024 = 3'h5, TC8_CS_EXT_FALL = 3'h6,
      TC8_CS_EXT_RISE = 3'h7
   } tc8_cs_t;
   // waveform modes: 0 normal, 1 phase pwm max, 2 clear on match, 3 fast pwm max,
   // 5 phase pwm to a, 7 fast pwm to a; 4 and 6 reserved, treated as normal
   localparam logic [2:0] TC8_WGM_NORMAL = 3'h0;
   localparam logic [2:0] TC8_WGM_PHASE  = 3'h1;
   localparam logic [2:0] TC8_WGM_CTC    = 3'h2;
   localparam logic [2:0] TC8_WGM_FAST   = 3'h3;
   localparam logic [2:0] TC8_WGM_PHASEA = 3'h5;
   localparam logic [2:0] TC8_WGM_FASTA  = 3'h7;
   typedef enum logic [2:0] {
      TC8_W_IDLE = 3'b001, TC8_W_RESP = 3'b010, TC8_W_HOLD = 3'b100
   } tc8_wst_t;
endpackage : tc8_pkg

// *** tc8_timer.sv ***
// Purpose: 8-bit timer/counter, two compare units, AXI4-Lite registers
// Assumes: single clock aclk, synchronous active-low reset aresetn
// Notes:   external count pin is synchronised before edge detection
// Function
// - counter and both compare values are 8-bit bus-visible registers
// - count zero is bottom, raising an internal bottom indication
// - count all-ones is maximum
// - top is maximum or compare value a, depending on mode
// - tick comes from prescaler or external pin, with edge choice
// - clock select zero gives no tick; counter stops
// - software may read and write the counter at any time
// - software counter write beats clear and count
// - each tick clears, increments or decrements by one per direction
// - three-bit waveform mode split over control a and b
// - overflow flag set where mode defines; can request interrupt
// - counter compared continuously with both compare values
// - compare flag sets on the tick after the match
// - enabled set flag requests interrupt; servicing clears it
// - writing one clears a flag; zero leaves it
// - flag register shows all three flags, not gated by the mask bits
// - compare values double-buffered in pwm modes only
// - buffered value moves to active only at top or bottom
// - buffering on: software sees buffer; off: active register
// - compare outputs formed from match, mode, output mode, top, bottom
// - mode zero counts up, wraps, overflow when count becomes zero
// - mode two clears counter on match with compare a
// - counter write blocks compare matches on the next tick
// - force strobe acts on output as a match in non-pwm modes
`timescale 1ns/1ps
`default_nettype none
module tc8_timer
   import tc8_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        external_count_pin,
   input  wire logic [2:0]  irq_ack,
   output var  logic [2:0]  irq_req,
   output var  logic        compare_output_a,
   output var  logic        compare_output_b
);
   typedef struct packed {
      logic [7:0]  ctrl_a;
      logic [7:0]  ctrl_b;
      logic [7:0]  count_value;
      logic [7:0]  cmp_a;
      logic [7:0]  cmp_b;
      logic [7:0]  buf_a;
      logic [7:0]  buf_b;
      logic [2:0]  flags;
      logic [2:0]  masks;
      logic        power_reduce;
      logic        dir_down;
      logic        block_match;
      logic [9:0]  presc;
      logic [2:0]  pin_sync;
      logic        oc_a;
      logic        oc_b;
      logic [2:0]  irq;
      tc8_wst_t    wst;
      logic        aw_got;
      logic        w_got;
      logic [7:0]  aw_addr;
      logic [31:0] w_data;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        aw_rdy;
      logic        w_rdy;
      logic        ar_rdy;
   } tc8_state_t;

   tc8_state_t st_r;
   tc8_state_t st_nxt;

   logic [2:0] wgm;
   logic       is_pwm;
   logic       is_fast;
   logic [7:0] top_val;
   logic       at_top;
   logic       at_bottom;
   logic       tick;
   logic       pin_rise;
   logic       pin_fall;
   logic [1:0] match;
   logic       wr_go;
   logic       load_buf;
   logic [7:0] rd_val;
   logic [7:0] wb;

   function automatic logic oc_next(input logic cur, input logic [1:0] com,
                                    input logic pwm, input logic up);
      logic r;
      r = cur;
      unique case (com)
         2'h1:    r = pwm ? cur : ~cur;
         2'h2:    r = pwm ? ~up : 1'b0;
         2'h3:    r = pwm ? up : 1'b1;
         default: r = cur;
      endcase
      return r;
   endfunction : oc_next

   always_comb begin
      wgm       = {st_r.ctrl_b[TC8_WGM2_POS], st_r.ctrl_a[1:0]};
      is_pwm    = (wgm == TC8_WGM_PHASE) || (wgm == TC8_WGM_FAST) ||
                  (wgm == TC8_WGM_PHASEA) || (wgm == TC8_WGM_FASTA);
      is_fast   = (wgm == TC8_WGM_FAST) || (wgm == TC8_WGM_FASTA);
      top_val   = (wgm == TC8_WGM_CTC || wgm == TC8_WGM_PHASEA || wgm == TC8_WGM_FASTA) ?
                  st_r.cmp_a : TC8_MAX;
      at_top    = (st_r.count_value == top_val);
      at_bottom = (st_r.count_value == TC8_BOTTOM);
      pin_rise  = st_r.pin_sync[1] & ~st_r.pin_sync[2];
      pin_fall  = ~st_r.pin_sync[1] & st_r.pin_sync[2];
      unique case (tc8_cs_t'(st_r.ctrl_b[2:0]))
         TC8_CS_DIV1:     tick = 1'b1;
         TC8_CS_DIV8:     tick = st_r.presc[2:0] == 3'h7;
         TC8_CS_DIV64:    tick = st_r.presc[5:0] == 6'h3F;
         TC8_CS_DIV256:   tick = st_r.presc[7:0] == 8'hFF;
         TC8_CS_DIV1024:  tick = st_r.presc == 10'h3FF;
         TC8_CS_EXT_FALL: tick = pin_fall;
         TC8_CS_EXT_RISE: tick = pin_rise;
         default:         tick = 1'b0;
      endcase
      if (st_r.power_reduce) begin
         tick = 1'b0;
      end
      match = {st_r.count_value == st_r.cmp_b, st_r.count_value == st_r.cmp_a};
      wr_go    = st_r.aw_got && st_r.w_got && st_r.wst == TC8_W_IDLE;
      wb       = st_r.w_data[7:0];
      // load at top, or bottom for phase pwm
      load_buf = is_pwm && tick && (is_fast ? at_top : at_bottom);
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.pin_sync = {st_r.pin_sync[1:0], external_count_pin};
      st_nxt.presc    = st_r.presc + 10'h001;
      st_nxt.bvalid   = st_r.bvalid && !s_axi_bready;
      st_nxt.rvalid   = st_r.rvalid && !s_axi_rready;
      rd_val = TC8_RESET8;

      if (tick) begin
         // flag set by the tick ending the match cycle
         if (!st_r.block_match && match[0]) st_nxt.flags[TC8_OCFA_POS] = 1'b1;
         if (!st_r.block_match && match[1]) st_nxt.flags[TC8_OCFB_POS] = 1'b1;
         st_nxt.block_match = 1'b0;
         if (!st_r.block_match && match[0])
            st_nxt.oc_a = oc_next(st_r.oc_a, st_r.ctrl_a[TC8_COMA_POS +: 2], is_pwm,
                                  !st_r.dir_down);
         if (!st_r.block_match && match[1])
            st_nxt.oc_b = oc_next(st_r.oc_b, st_r.ctrl_a[TC8_COMB_POS +: 2], is_pwm,
                                  !st_r.dir_down);
         if (is_fast && at_top) begin
            if (st_r.ctrl_a[TC8_COMA_POS +: 2] == 2'h2) st_nxt.oc_a = 1'b1;
            if (st_r.ctrl_a[TC8_COMA_POS +: 2] == 2'h3) st_nxt.oc_a = 1'b0;
            if (st_r.ctrl_a[TC8_COMB_POS +: 2] == 2'h2) st_nxt.oc_b = 1'b1;
            if (st_r.ctrl_a[TC8_COMB_POS +: 2] == 2'h3) st_nxt.oc_b = 1'b0;
         end
         if (is_pwm && !is_fast) begin
            if (at_top) st_nxt.dir_down = 1'b1;
            else if (at_bottom) st_nxt.dir_down = 1'b0;
            st_nxt.count_value = (at_top || (st_r.dir_down && !at_bottom)) ?
                                 st_r.count_value - 8'h01 : st_r.count_value + 8'h01;
            if (at_bottom) st_nxt.flags[TC8_OVF_POS] = 1'b1;
         end else if (is_fast || wgm == TC8_WGM_CTC) begin
            st_nxt.dir_down    = 1'b0;
            st_nxt.count_value = at_top ? TC8_BOTTOM : st_r.count_value + 8'h01;
            // overflow at max or top per mode
            if (is_fast ? at_top : st_r.count_value == TC8_MAX)
               st_nxt.flags[TC8_OVF_POS] = 1'b1;
         end else begin
            st_nxt.dir_down    = 1'b0;
            st_nxt.count_value = st_r.count_value + 8'h01;
            if (st_r.count_value == TC8_MAX) st_nxt.flags[TC8_OVF_POS] = 1'b1;
         end
         if (load_buf) begin
            st_nxt.cmp_a = st_r.buf_a;
            st_nxt.cmp_b = st_r.buf_b;
         end
      end
      if (!is_pwm) begin
         st_nxt.buf_a = st_r.cmp_a;
         st_nxt.buf_b = st_r.cmp_b;
      end

      // serviced interrupt clears its flag, unless set again now
      for (int i = 0; i < 3; i++) begin
         if (irq_ack[i] && !(st_nxt.flags[i] && !st_r.flags[i])) st_nxt.flags[i] = 1'b0;
      end

      // write channel; one write in flight, response before next
      if (s_axi_awvalid && !st_r.aw_got) begin
         st_nxt.aw_got  = 1'b1;
         st_nxt.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st_r.w_got) begin
         st_nxt.w_got  = 1'b1;
         st_nxt.w_data = s_axi_wstrb[0] ? s_axi_wdata : 32'h0;
      end
      unique case (st_r.wst)
         TC8_W_IDLE: begin
            if (wr_go) begin
               st_nxt.wst    = TC8_W_RESP;
               st_nxt.bvalid = 1'b1;
               st_nxt.bresp  = TC8_RESP_OKAY;
               unique case (st_r.aw_addr)
                  TC8_CTRL_A_OFS: st_nxt.ctrl_a = wb;
                  TC8_CTRL_B_OFS: begin
                     st_nxt.ctrl_b = {2'b00, wb[5:0]};
                     // force acts only in non-pwm modes
                     if (!is_pwm && wb[TC8_FOCA_POS])
                        st_nxt.oc_a = oc_next(st_r.oc_a, st_r.ctrl_a[TC8_COMA_POS +: 2],
                                              1'b0, 1'b1);
                     if (!is_pwm && wb[TC8_FOCB_POS])
                        st_nxt.oc_b = oc_next(st_r.oc_b, st_r.ctrl_a[TC8_COMB_POS +: 2],
                                              1'b0, 1'b1);
                  end
                  TC8_COUNT_OFS: begin
                     st_nxt.count_value = wb;
                     st_nxt.block_match = 1'b1;
                  end
                  TC8_CMPA_OFS: if (is_pwm) st_nxt.buf_a = wb; else st_nxt.cmp_a = wb;
                  TC8_CMPB_OFS: if (is_pwm) st_nxt.buf_b = wb; else st_nxt.cmp_b = wb;
                  TC8_MASK_OFS: st_nxt.masks = wb[2:0];
                  TC8_FLAG_OFS: begin
                     // write one clears; a same-cycle set wins
                     for (int i = 0; i < 3; i++) begin
                        if (wb[i] && !(st_nxt.flags[i] && !st_r.flags[i]))
                           st_nxt.flags[i] = 1'b0;
                     end
                  end
                  TC8_POWER_OFS: st_nxt.power_reduce = wb[0];
                  default: st_nxt.bresp = TC8_RESP_SLVERR;
               endcase
            end
         end
         TC8_W_RESP: begin
            if (s_axi_bready) begin
               st_nxt.wst    = TC8_W_HOLD;
               st_nxt.aw_got = 1'b0;
               st_nxt.w_got  = 1'b0;
            end
         end
         TC8_W_HOLD: st_nxt.wst = TC8_W_IDLE;
      endcase

      // read channel
      unique case (s_axi_araddr)
         TC8_CTRL_A_OFS: rd_val = st_r.ctrl_a;
         TC8_CTRL_B_OFS: rd_val = st_r.ctrl_b;
         TC8_COUNT_OFS:  rd_val = st_r.count_value;
         TC8_CMPA_OFS:   rd_val = is_pwm ? st_r.buf_a : st_r.cmp_a;
         TC8_CMPB_OFS:   rd_val = is_pwm ? st_r.buf_b : st_r.cmp_b;
         TC8_MASK_OFS:   rd_val = {5'h00, st_r.masks};
         TC8_FLAG_OFS:   rd_val = {5'h00, st_r.flags};
         TC8_POWER_OFS:  rd_val = {7'h00, st_r.power_reduce};
         default:        rd_val = TC8_RESET8;
      endcase
      if (s_axi_arvalid && !st_r.rvalid) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rdata  = {24'h000000, rd_val};
         st_nxt.rresp  = (s_axi_araddr <= TC8_POWER_OFS && s_axi_araddr[1:0] == 2'h0) ?
                         TC8_RESP_OKAY : TC8_RESP_SLVERR;
      end
      st_nxt.irq = st_nxt.flags & st_nxt.masks;
      // readies kept in flops so no port is combinational
      st_nxt.aw_rdy = !st_nxt.aw_got;
      st_nxt.w_rdy  = !st_nxt.w_got;
      st_nxt.ar_rdy = !st_nxt.rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r          <= '0;
         st_r.wst      <= TC8_W_IDLE;
         st_r.aw_rdy   <= 1'b1;
         st_r.w_rdy    <= 1'b1;
         st_r.ar_rdy   <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign s_axi_awready   = st_r.aw_rdy;
   assign s_axi_wready    = st_r.w_rdy;
   assign s_axi_bvalid    = st_r.bvalid;
   assign s_axi_bresp     = st_r.bresp;
   assign s_axi_arready   = st_r.ar_rdy;
   assign s_axi_rvalid    = st_r.rvalid;
   assign s_axi_rdata     = st_r.rdata;
   assign s_axi_rresp     = st_r.rresp;
   assign irq_req         = st_r.irq;
   assign compare_output_a = st_r.oc_a;
   assign compare_output_b = st_r.oc_b;
endmodule : tc8_timer
`default_nettype wire

// *** tc8_timer_sva.sv ***
// Purpose: port-level checks on the register bus of the 8-bit timer
// Assumes: single clock aclk, synchronous active-low aresetn
// Notes:   response latencies follow the designer's hand-over figures
`timescale 1ns/1ps
`default_nettype none
module tc8_timer_sva
   import tc8_pkg::*;
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence wr_taken_s;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence b_answer_s;
      !s_axi_bvalid ##1 s_axi_bvalid;
   endsequence
   wr_answer_a:
   assert property (wr_taken_s |=> b_answer_s) else $error("write answer late or early");
   b_hold_a:
   assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   wr_refuse_a:
   assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   rd_answer_a:
   assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
   r_hold_a:
   assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
      && $stable(s_axi_rresp)) else $error("read data dropped");
   r_drop_a:
   assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read repeated");
   ar_link_a:
   assert property (s_axi_arready != s_axi_rvalid) else $error("arready not inverse of rvalid");
   rdata_width_a:
   assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper data bits set");
endmodule : tc8_timer_sva
bind tc8_timer tc8_timer_sva tc8_timer_sva_i (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready));
`default_nettype wire

// *** testbench.sv ***
// Purpose: self-checking bench for the 8-bit timer through its register bus
// Assumes: 10 MHz aclk, reads compared by a monitor from a queue of notes
// Notes:   prescaler runs at div1 so counts stay short
`timescale 1ns/1ps
`default_nettype none
module testbench
   import tc8_pkg::*;
;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, pin;
   logic        awready, wready, bvalid, arready, rvalid, out_a, out_b;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, v;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic [2:0]  irq_ack, irq_req;
   logic [33:0] rd_q[$];
   logic [1:0]  wr_q[$];
   logic [33:0] e;
   int          n_mismatch, check_count, cycles, seed, i;
   tc8_timer tc8_timer_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .external_count_pin(pin), .irq_ack(irq_ack), .irq_req(irq_req),
      .compare_output_a(out_a), .compare_output_b(out_b));
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : complete_run
   // aw and w offered together; each released once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
      bit aw_d, w_d;
      wr_q.push_back(r);
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      aw_d = 0; w_d = 0;
      while (!(aw_d && w_d)) begin
         @(posedge aclk);
         if (awvalid && awready) begin awvalid <= 1'b0; aw_d = 1; end
         if (wvalid && wready) begin wvalid <= 1'b0; w_d = 1; end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      // idle edge: the slave spends one cycle in TC8_W_HOLD, with awready and wready already high
      @(posedge aclk);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
      rd_q.push_back({r, d});
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      @(posedge aclk);
   endtask : rd
   // pin held four cycles each level so the synchroniser sees every edge
   task automatic pulse(input int n);
      repeat (n) begin
         pin <= 1'b1; repeat (4) @(posedge aclk);
         pin <= 1'b0; repeat (4) @(posedge aclk);
      end
   endtask : pulse
   task automatic wait_irq(input int b);
      for (i = 0; i < 300 && irq_req[b] !== 1'b1; i++) @(posedge aclk);
      chk("irq_req bit", 32'h1, {31'h0, irq_req[b]});
   endtask : wait_irq
   always @(posedge aclk) begin
      if (rvalid && rready && rd_q.size() > 0) begin
         e = rd_q.pop_front();
         chk("rdata", e[31:0], rdata);
         chk("rresp", {30'h0, e[33:32]}, {30'h0, rresp});
      end
      if (bvalid && bready && wr_q.size() > 0)
         chk("bresp", {30'h0, wr_q.pop_front()}, {30'h0, bresp});
   end
   // ceiling well above the roughly 360 cycles the sequence needs
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 5000) begin n_mismatch++; complete_run(); end
   end
   initial begin
      seed = 66793; aresetn = 1'b0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0;
      rready = 0; pin = 0; awaddr = 0; araddr = 0; wdata = 0; wstrb = 4'hF; irq_ack = 0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int k = 0; k < 8; k++) rd(8'(k * 4), 32'h0);
      rd(8'h24, 32'h0, TC8_RESP_SLVERR);
      chk("outputs", 32'h0, {27'h0, irq_req, out_a, out_b});
      $display("test reset_values done");
      v = {24'h0, 8'($random(seed))};
      wr(TC8_COUNT_OFS, v); repeat (20) @(posedge aclk); rd(TC8_COUNT_OFS, v);
      wr(8'h24, v, TC8_RESP_SLVERR);
      wr(TC8_COUNT_OFS, 0); wr(TC8_CTRL_B_OFS, 7); pulse(3); rd(TC8_COUNT_OFS, 3);
      wr(TC8_CTRL_B_OFS, 6); pulse(2); wr(TC8_CTRL_B_OFS, 0); rd(TC8_COUNT_OFS, 5);
      $display("test stopped_and_pin done");
      wr(TC8_CMPA_OFS, 8'h80); wr(TC8_CMPB_OFS, 8'h80); rd(TC8_CMPA_OFS, 8'h80);
      wr(TC8_MASK_OFS, 1); wr(TC8_COUNT_OFS, 8'hFD); wr(TC8_CTRL_B_OFS, 1); wait_irq(0);
      wr(TC8_CTRL_B_OFS, 0); rd(TC8_FLAG_OFS, 1); chk("irq_req", 1, {29'h0, irq_req});
      irq_ack <= 3'h1; @(posedge aclk); irq_ack <= 3'h0; @(posedge aclk);
      rd(TC8_FLAG_OFS, 0); chk("irq_req", 0, {29'h0, irq_req});
      $display("test overflow done");
      wr(TC8_CMPA_OFS, 0); wr(TC8_CMPB_OFS, 0); wr(TC8_MASK_OFS, 6); wr(TC8_CTRL_A_OFS, 2);
      wr(TC8_COUNT_OFS, 0); wr(TC8_CTRL_B_OFS, 1); wait_irq(1); wr(TC8_CTRL_B_OFS, 0);
      rd(TC8_COUNT_OFS, 0); rd(TC8_FLAG_OFS, 6);
      wr(TC8_FLAG_OFS, 2); rd(TC8_FLAG_OFS, 4); wr(TC8_FLAG_OFS, 4); rd(TC8_FLAG_OFS, 0);
      $display("test clear_on_match done");
      wr(TC8_CTRL_A_OFS, 0); wr(TC8_CMPA_OFS, 8'h40); wr(TC8_COUNT_OFS, 8'h40);
      wr(TC8_CTRL_B_OFS, 1); wr(TC8_CTRL_B_OFS, 0); rd(TC8_FLAG_OFS, 0);
      wr(TC8_CTRL_A_OFS, 8'h50); wr(TC8_CTRL_B_OFS, 8'hC0);
      chk("compare outputs", 32'h3, {30'h0, out_a, out_b});
      rd(TC8_FLAG_OFS, 0); rd(TC8_CTRL_B_OFS, 0);
      $display("test block_and_force done");
      // software keeps the timer powered down here, so the count must hold
      wr(TC8_POWER_OFS, 1); wr(TC8_COUNT_OFS, 8'h20); wr(TC8_CTRL_B_OFS, 1);
      repeat (10) @(posedge aclk);
      wr(TC8_CTRL_B_OFS, 0); rd(TC8_COUNT_OFS, 8'h20); wr(TC8_POWER_OFS, 0);
      $display("test power_reduce done");
      // phase pwm: writes go to the buffer, count turns at maximum
      wr(TC8_CTRL_A_OFS, 1); wr(TC8_COUNT_OFS, 8'hFE); wr(TC8_CMPA_OFS, 8'h11);
      rd(TC8_CMPA_OFS, 8'h11);
      wr(TC8_CTRL_B_OFS, 1); wr(TC8_CTRL_B_OFS, 0); rd(TC8_COUNT_OFS, 8'hFC);
      wr(TC8_CTRL_A_OFS, 0); rd(TC8_CMPA_OFS, 8'h40);
      wr(TC8_CTRL_A_OFS, 1); wr(TC8_CMPA_OFS, 8'h11); wr(TC8_COUNT_OFS, 1);
      wr(TC8_CTRL_B_OFS, 1); wr(TC8_CTRL_B_OFS, 0); rd(TC8_COUNT_OFS, 3);
      wr(TC8_CTRL_A_OFS, 0); rd(TC8_CMPA_OFS, 8'h11);
      $display("test pwm_buffer done");
      @(posedge aclk);
      complete_run();
   end
endmodule : testbench
`default_nettype wire
